// ==== design/fbp_pkg.sv ====
`default_nettype none
package fbp_pkg;
    // command addresses of the filament registers
    localparam logic [7:0] REG_ON_COUNT = 8'h09;
    localparam logic [7:0] REG_FN_A = 8'h0A;
    localparam logic [7:0] REG_FN_B = 8'h0B;
    // pin function field sits in data bits 1:0
    localparam int FN_LSB = 0;
    localparam int FN_W = 2;
    // reset values
    localparam logic [7:0] ON_COUNT_RST = 8'h01;
    localparam logic [1:0] FN_RST = 2'h0;
    // pin function codes
    localparam logic [1:0] FN_STATIC0 = 2'h0;
    localparam logic [1:0] FN_STATIC1 = 2'h1;
    localparam logic [1:0] FN_BLINK = 2'h2;
    localparam logic [1:0] FN_FILAMENT = 2'h3;
    // period timing in oscillator cycles
    localparam logic [7:0] PERIOD_BASE = 8'hC7;
    localparam logic [7:0] DEAD_CYCLES = 8'h02;
    localparam logic [7:0] ON_MIN = 8'h01;
    localparam logic [7:0] ON_MAX = 8'hC7;
    localparam logic [7:0] IDLE_MIN = 8'h01;
    // filament period segments
    typedef enum logic [4:0] {
        ST_IDLE_A = 5'b00001,
        ST_DRIVE_B = 5'b00010,
        ST_DEAD = 5'b00100,
        ST_DRIVE_A = 5'b01000,
        ST_IDLE_E = 5'b10000
    } fbp_seg_t;
endpackage
`default_nettype wire

// ==== design/fbp_link_if.sv ====
`default_nettype none
interface fbp_link_if;
    import fbp_pkg::*;
    logic [7:0] on_count;
    logic run;
    logic wave_a;
    logic wave_b;
    logic period_start;
    modport seq (input on_count, input run, output wave_a, output wave_b, output period_start);
    modport ctl (output on_count, output run, input wave_a, input wave_b, input period_start);
endinterface
`default_nettype wire

// ==== design/fbp_seq.sv ====
`default_nettype none
module fbp_seq
    import fbp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link to the register side
    fbp_link_if.seq lnk
);
    fbp_seg_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] on_lat_q, on_lat_d;
    logic seg_end;

    // out-of-range settings are pulled into 1..199 so the period never stalls
    function automatic logic [7:0] clamp_on(input logic [7:0] n);
        if (n < ON_MIN) return ON_MIN;
        if (n > ON_MAX) return ON_MAX; // RQ5
        return n;
    endfunction

    // length of each segment; idle keeps at least one cycle at the top setting
    function automatic logic [7:0] seg_len(input fbp_seg_t s, input logic [7:0] n);
        case (s)
            ST_DRIVE_B, ST_DRIVE_A: return n;
            ST_DEAD: return DEAD_CYCLES;
            default: return (n >= PERIOD_BASE) ? IDLE_MIN : 8'(PERIOD_BASE - n); // RQ5
        endcase
    endfunction

    assign seg_end = (cnt_q == 8'(seg_len(state_q, on_lat_q) - 8'h01));

    // segment sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = 8'(cnt_q + 8'h01);
        on_lat_d = on_lat_q;
        if (!lnk.run) begin
            state_d = ST_IDLE_A;
            cnt_d = 8'h00;
            on_lat_d = clamp_on(lnk.on_count);
        end else if (seg_end) begin
            cnt_d = 8'h00;
            case (state_q)
                ST_IDLE_A: state_d = ST_DRIVE_B; // RQ1
                ST_DRIVE_B: state_d = ST_DEAD; // RQ1
                ST_DEAD: state_d = ST_DRIVE_A; // RQ1
                ST_DRIVE_A: state_d = ST_IDLE_E; // RQ1
                ST_IDLE_E: begin
                    state_d = ST_IDLE_A; // RQ13
                    on_lat_d = clamp_on(lnk.on_count); // RQ13
                end
                default: state_d = ST_IDLE_A;
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE_A;
            cnt_q <= 8'h00;
            on_lat_q <= ON_COUNT_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            on_lat_q <= on_lat_d;
        end
    end

    // waves decode straight from the state flops, so no glitches reach the pins
    assign lnk.wave_b = (state_q == ST_DRIVE_B); // RQ2
    assign lnk.wave_a = (state_q == ST_DRIVE_A); // RQ3
    assign lnk.period_start = lnk.run && (state_q == ST_IDLE_E) && seg_end;

    // helper: length of the current high pulse on each wave
    logic [7:0] hi_a_q, hi_a_d, hi_b_q, hi_b_d, lo_q, lo_d;
    always_comb begin
        hi_a_d = lnk.wave_a ? 8'(hi_a_q + 8'h01) : 8'h00;
        hi_b_d = lnk.wave_b ? 8'(hi_b_q + 8'h01) : 8'h00;
        lo_d = (state_q == ST_DEAD) ? 8'(lo_q + 8'h01) : 8'h00;
    end

    // helper registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hi_a_q <= 8'h00;
            hi_b_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_a_q <= hi_a_d;
            hi_b_q <= hi_b_d;
            lo_q <= lo_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_b_pulse_len: assert property ($fell(lnk.wave_b) && $past(lnk.run) |-> // RQ2
        hi_b_q == on_lat_q) else $error("phase B pulse length differs from on-count");
    a_a_pulse_len: assert property ($fell(lnk.wave_a) && $past(lnk.run) |-> // RQ3
        hi_a_q == $past(on_lat_q)) else $error("phase A pulse length differs from on-count");
    a_dead_time: assert property (lnk.run && state_q == ST_DRIVE_B && seg_end |=> // RQ1
        (state_q == ST_DEAD) [*2] ##1 lnk.wave_a) else $error("dead time is not two cycles");
    a_never_both: assert property (!(lnk.wave_a && lnk.wave_b)) // RQ1
        else $error("both phases driven at once");
    a_count_stable: assert property (!lnk.period_start && lnk.run && $past(lnk.run) |=> // RQ13
        $stable(on_lat_q)) else $error("on-count changed inside a period");
    a_period_gapless: assert property (lnk.period_start && lnk.run |=> // RQ13
        state_q == ST_IDLE_A && cnt_q == 8'h00) else $error("gap between periods");

    c_dead: cover property (lo_q == DEAD_CYCLES);
    c_period: cover property (lnk.period_start);
    c_max_on: cover property (lnk.wave_a && on_lat_q == ON_MAX);
endmodule
`default_nettype wire

// ==== design/fbp_top.sv ====
`default_nettype none
// Overview of operation
// RQ1 - Every period runs idle low, phase B drive, two low dead cycles, phase A drive, idle low.
// RQ2 - In the first drive segment phase A is low and phase B high for on-count cycles.
// RQ3 - In the second drive segment phase A is high and phase B low for on-count cycles.
// RQ4 - The on-count lives in an eight-bit register at command address 0x09, smallest useful 1.
// RQ5 - The largest useful on-count is 199, which leaves one cycle in each idle segment.
// RQ6 - Phase A pin function comes from bits 1:0 at address 0x0A; bits 7:2 are ignored.
// RQ7 - Code 00 drives phase A as static low and is the power-up selection.
// RQ8 - Code 01 drives phase A as static high.
// RQ9 - Code 10 shows the blink phase on phase A: low in the first, high in the second.
// RQ10 - Code 11 puts the phase A filament waveform on the pin.
// RQ11 - In shutdown with the filament function selected phase A is forced low.
// RQ12 - Phase B has the same four selections at address 0x0B and is low in shutdown on code 11.
// RQ13 - Periods repeat without gaps and a new on-count takes effect at the next period.
module fbp_top
    import fbp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // command register write port
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_data,
    // command register read port
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    // display state from the controller core
    input wire logic shutdown,
    input wire logic blink_phase_second,
    // bridge pins
    output logic filament_phase_a_out,
    output logic filament_phase_b_out
);
    logic [7:0] on_count_q, on_count_d;
    logic [1:0] fn_a_q, fn_a_d;
    logic [1:0] fn_b_q, fn_b_d;
    logic [7:0] rd_q, rd_d;
    logic pin_a_q, pin_a_d;
    logic pin_b_q, pin_b_d;

    fbp_link_if lnk ();

    fbp_seq u_seq (
        .clk(clk),
        .sys_rst(sys_rst),
        .lnk(lnk.seq)
    );

    assign lnk.on_count = on_count_q;
    assign lnk.run = !shutdown;

    // one mux serves both pins, so the two selections cannot drift apart
    function automatic logic pin_sel(input logic [1:0] fn, input logic blink,
                                     input logic wave, input logic sd);
        case (fn)
            FN_STATIC0: return 1'b0; // RQ7
            FN_STATIC1: return 1'b1; // RQ8
            FN_BLINK: return blink; // RQ9
            default: return sd ? 1'b0 : wave; // RQ10 RQ11
        endcase
    endfunction

    // register writes; upper data bits of the function registers are dropped
    always_comb begin
        on_count_d = on_count_q;
        fn_a_d = fn_a_q;
        fn_b_d = fn_b_q;
        if (reg_wr) begin
            case (reg_wr_addr)
                REG_ON_COUNT: on_count_d = reg_wr_data; // RQ4 RQ5
                REG_FN_A: fn_a_d = reg_wr_data[FN_LSB +: FN_W]; // RQ6
                REG_FN_B: fn_b_d = reg_wr_data[FN_LSB +: FN_W]; // RQ12
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero, ignored bits read zero
    always_comb begin
        case (reg_rd_addr)
            REG_ON_COUNT: rd_d = on_count_q;
            REG_FN_A: rd_d = {6'h00, fn_a_q};
            REG_FN_B: rd_d = {6'h00, fn_b_q};
            default: rd_d = 8'h00;
        endcase
    end

    // pin levels; registered so the bridge sees clean edges one cycle late
    always_comb begin
        pin_a_d = pin_sel(fn_a_q, blink_phase_second, lnk.wave_a, shutdown);
        pin_b_d = pin_sel(fn_b_q, blink_phase_second, lnk.wave_b, shutdown); // RQ12
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            on_count_q <= ON_COUNT_RST;
            fn_a_q <= FN_RST; // RQ7
            fn_b_q <= FN_RST;
            rd_q <= 8'h00;
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else begin
            on_count_q <= on_count_d;
            fn_a_q <= fn_a_d;
            fn_b_q <= fn_b_d;
            rd_q <= rd_d;
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
        end
    end

    assign reg_rd_data = rd_q;
    assign filament_phase_a_out = pin_a_q;
    assign filament_phase_b_out = pin_b_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_fn_a_write: assert property (reg_wr && reg_wr_addr == REG_FN_A |=> // RQ6
        fn_a_q == $past(reg_wr_data[1:0])) else $error("phase A function write not taken");
    // the read port answers one cycle late; upper function bits always read zero
    a_rd_fn_a: assert property (reg_rd_addr == REG_FN_A |=> // RQ6
        reg_rd_data == {6'h00, $past(fn_a_q)}) else $error("phase A function read wrong");
    a_rd_fn_b: assert property (reg_rd_addr == REG_FN_B |=> // RQ12
        reg_rd_data == {6'h00, $past(fn_b_q)}) else $error("phase B function read wrong");
    a_rd_count: assert property (reg_rd_addr == REG_ON_COUNT |=> // RQ4
        reg_rd_data == $past(on_count_q)) else $error("on-count read wrong");
    a_count_write: assert property (reg_wr && reg_wr_addr == REG_ON_COUNT |=> // RQ4
        on_count_q == $past(reg_wr_data)) else $error("on-count write not taken");
    a_static_low: assert property (fn_a_q == FN_STATIC0 |=> // RQ7
        !filament_phase_a_out) else $error("phase A not static low");
    a_static_high: assert property (fn_a_q == FN_STATIC1 |=> // RQ8
        filament_phase_a_out) else $error("phase A not static high");
    a_blink_follow: assert property (fn_a_q == FN_BLINK |=> // RQ9
        filament_phase_a_out == $past(blink_phase_second)) else $error("blink not shown");
    a_wave_follow: assert property (fn_a_q == FN_FILAMENT && !shutdown |=> // RQ10
        filament_phase_a_out == $past(lnk.wave_a)) else $error("phase A wave not on pin");
    a_shutdown_low: assert property (shutdown && fn_a_q == FN_FILAMENT |=> // RQ11
        !filament_phase_a_out) else $error("phase A high in shutdown");
    a_b_select: assert property (fn_b_q == FN_FILAMENT |=> // RQ12
        filament_phase_b_out == ($past(lnk.wave_b) && !$past(shutdown)))
        else $error("phase B filament selection wrong");
    a_reset_fn: assert property ($past(sys_rst) |-> fn_a_q == FN_STATIC0 && // RQ7
        fn_b_q == FN_STATIC0) else $error("function not static low after reset");
    // pins and read data leave reset low, so the bridge never sees a stray pulse
    a_pins_reset: assert property ($past(sys_rst) |-> !filament_phase_a_out && // RQ7
        !filament_phase_b_out && reg_rd_data == 8'h00) else $error("outputs not low after reset");
    // phase B shares the mux, but its own register must steer it
    a_b_static_low: assert property (fn_b_q == FN_STATIC0 |=> // RQ12
        !filament_phase_b_out) else $error("phase B not static low");
    a_b_static_high: assert property (fn_b_q == FN_STATIC1 |=> // RQ12
        filament_phase_b_out) else $error("phase B not static high");
    a_b_blink: assert property (fn_b_q == FN_BLINK |=> // RQ12
        filament_phase_b_out == $past(blink_phase_second)) else $error("blink not shown on B");
    a_b_write: assert property (reg_wr && reg_wr_addr == REG_FN_B |=> // RQ12
        fn_b_q == $past(reg_wr_data[1:0])) else $error("phase B function write not taken");

    c_fil_on: cover property (fn_a_q == FN_FILAMENT && filament_phase_a_out);
    c_shutdown: cover property (fn_b_q == FN_FILAMENT && shutdown ##1 !shutdown);
endmodule
`default_nettype wire

// ==== test/fbp_bridge_model.sv ====
`default_nettype none
module fbp_bridge_model (
    // clock
    input wire logic clk,
    // gate drive taken from the two pins
    input wire logic phase_a,
    input wire logic phase_b,
    // cycles in which both legs conduct at once
    output logic [15:0] shoot_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // both legs on together would short the filament supply
    initial shoot_cnt = 16'h0000;
    always @(posedge clk) begin
        if (phase_a === 1'b1 && phase_b === 1'b1) begin
            shoot_cnt <= shoot_cnt + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb import fbp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, reg_wr, shutdown, blink_phase_second;
    logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, v;
    logic filament_phase_a_out, filament_phase_b_out;
    logic [15:0] shoot_cnt;
    int failures, n_checks;
    fbp_top fbp_top_i (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .shutdown(shutdown),
        .blink_phase_second(blink_phase_second),
        .filament_phase_a_out(filament_phase_a_out),
        .filament_phase_b_out(filament_phase_b_out));
    fbp_bridge_model fbp_bridge_model_i (.clk(clk), .phase_a(filament_phase_a_out),
        .phase_b(filament_phase_b_out), .shoot_cnt(shoot_cnt));
    // 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // inputs always move 2 ns after the edge, clear of sampling
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    // strobe drops for a cycle so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_wr_addr = a;
        reg_wr_data = d;
        step();
        reg_wr = 1'b0;
        step();
    endtask
    // read data is registered: one edge after the address
    task automatic rd(input logic [7:0] a);
        reg_rd_addr = a;
        step();
        v = reg_rd_data;
    endtask
    task automatic rise_b();
        int k;
        k = 0;
        while (filament_phase_b_out !== 1'b0 && k < 1000) begin k++; step(); end
        while (filament_phase_b_out !== 1'b1 && k < 1000) begin k++; step(); end
        `CHK("rise_b", 1'b1, filament_phase_b_out)
    endtask
    task automatic t_reset();
        step();
        `CHK("pin_a_rst", 1'b0, filament_phase_a_out)
        `CHK("pin_b_rst", 1'b0, filament_phase_b_out)
        rd(REG_ON_COUNT);
        `CHK("on_rst", 8'h01, v)
        rd(REG_FN_A);
        `CHK("fn_a_rst", 8'h00, v)
        rd(REG_FN_B);
        `CHK("fn_b_rst", 8'h00, v)
    endtask
    // upper data bits and unmapped addresses must leave no trace
    task automatic t_regs();
        wr(REG_ON_COUNT, 8'h5A);
        wr(REG_FN_A, 8'hFE);
        wr(REG_FN_B, 8'hFD);
        wr(8'h0C, 8'h77);
        rd(REG_ON_COUNT);
        `CHK("on_rw", 8'h5A, v)
        rd(REG_FN_A);
        `CHK("fn_a_rw", 8'h02, v)
        rd(REG_FN_B);
        `CHK("fn_b_rw", 8'h01, v)
        rd(8'h0C);
        `CHK("unmapped", 8'h00, v)
    endtask
    task automatic t_static();
        logic e;
        for (int c = 0; c < 3; c++) begin
            wr(REG_FN_A, 8'hFC | 8'(c));
            wr(REG_FN_B, 8'hFC | 8'(c));
            for (int b = 0; b < 2; b++) begin
                blink_phase_second = b[0];
                step();
                step();
                e = (c == 2) ? b[0] : c[0];
                `CHK("pin_a_fn", e, filament_phase_a_out)
                `CHK("pin_b_fn", e, filament_phase_b_out)
            end
        end
    endtask
    // second rise always starts a whole period with the new count
    task automatic t_wave(input logic [7:0] n);
        int hb, dd, ha, gap, en;
        logic [15:0] s0;
        hb = 0;
        dd = 0;
        ha = 0;
        gap = 0;
        en = int'(n);
        wr(REG_FN_A, 8'(FN_FILAMENT));
        wr(REG_FN_B, 8'(FN_FILAMENT));
        wr(REG_ON_COUNT, n);
        rise_b();
        s0 = shoot_cnt;
        rise_b();
        while (filament_phase_b_out === 1'b1 && filament_phase_a_out === 1'b0 && hb < 500)
        begin hb++; step(); end
        while (filament_phase_b_out === 1'b0 && filament_phase_a_out === 1'b0 && dd < 500)
        begin dd++; step(); end
        while (filament_phase_a_out === 1'b1 && filament_phase_b_out === 1'b0 && ha < 500)
        begin ha++; step(); end
        while (filament_phase_b_out === 1'b0 && filament_phase_a_out === 1'b0 && gap < 500)
        begin gap++; step(); end
        `CHK("seg_b", en, hb)
        `CHK("dead", 2, dd)
        `CHK("seg_a", en, ha)
        `CHK("idle", (en > 198) ? 2 : 2 * (199 - en), gap)
        `CHK("shoot", s0, shoot_cnt)
    endtask
    task automatic t_shutdown();
        int hi;
        hi = 0;
        shutdown = 1'b1;
        step();
        repeat (450) begin
            step();
            if (filament_phase_a_out !== 1'b0 || filament_phase_b_out !== 1'b0) hi++;
        end
        `CHK("sd_low", 0, hi)
        shutdown = 1'b0;
        rise_b();
    endtask
    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // the whole sequence needs about 3700 cycles
    initial begin
        #2000000;
        failures++;
        results();
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_wr_addr = 8'h00;
        reg_wr_data = 8'h00;
        reg_rd_addr = 8'h00;
        shutdown = 1'b0;
        blink_phase_second = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (12) step();
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_static();
        t_wave(8'h01);
        t_wave(8'h64);
        t_wave(8'hC7);
        t_shutdown();
        // a second reset in mid-run must bring back the power-up state
        sys_rst = 1'b1;
        repeat (2) step();
        sys_rst = 1'b0;
        t_reset();
        results();
    end
endmodule
`default_nettype wire
